// File: src/hbi_pkg.sv
// ============================================================================
// host bus interface package: strobe styles, imc modes, address layout
// ============================================================================
// assumes a single 25 MHz clock; host pins are already synchronous to it.
// Contract
// - host type selects roles of three control inputs and two auxiliary pins
// - non-multiplexed hosts may skip the address strobe; address taken directly
// - third control input becomes a logic input when the host type leaves it unused
// - multiplexed mode captures address from the address/data port on the strobe
// - latched host address may be presented on an output port
// - multiplexed mode drives address/data port only on internal read
// - multiplexed mode accepts extra high address bits on other ports
// - 16-bit non-multiplexed mode: address on port, data on ports F and G
// - non-multiplexed data pins stay undriven unless the host reads the device
// - non-multiplexed mode accepts extra high address bits on other ports
// - input macrocells can capture high address bits with the address strobe
// - host can read input macrocell outputs in a normal read cycle
// - macrocell enable per nibble comes from product term or address strobe
// - 16-bit bus: address bit zero and byte enables select data lanes
// - burst fetch keeps upper address latched while host steps low bits
package hbi_pkg;
    // host strobe styles
    typedef enum logic [1:0] {
        STY_WR_RD_BHE,   // wr, rd, bhe or fetch strobe
        STY_WRL_WRH,     // wrl, rd, fetch; write high on aux pin
        STY_RW_DS_SIZ,   // r/w, data strobe, size bit
        STY_RW_LDS_UDS   // r/w, low and high byte strobes
    } hbi_style_e;

    localparam logic [1:0] IMC_PASS  = 2'h0;
    localparam logic [1:0] IMC_LATCH = 2'h1;
    localparam logic [1:0] IMC_REG   = 2'h2;

    localparam int         LO_W      = 16;   // address/data port width
    localparam int         HI_W      = 4;    // extra high address bits
    localparam int         FULL_W    = 20;
    localparam int         IMC_BITS  = 24;
    localparam int         NIB_CNT   = 6;

    localparam logic [1:0]  LANES_OFF    = 2'h3;   // both oe_n high
    localparam logic [7:0]  RES_BASE_DEF = 8'h00;  // address bits 19:12
    localparam logic [7:0]  RES_MASK_DEF = 8'hC0;
    localparam logic [17:0] IMC_WORD_DEF = 18'h03FC0; // address bits 19:2
endpackage : hbi_pkg

// File: src/hbi_top.sv
// ============================================================================
// host bus interface: strobe decode, address latch, data pins, input macrocells
// ============================================================================
// assumes host strobes and pins are sampled on clk_in; internal resources
// answer combinationally on int_rdata_in for the registered int_addr_out.
`timescale 1ns/10ps
module hbi_top import hbi_pkg::*; #(
    parameter logic [7:0]  RES_BASE = RES_BASE_DEF,
    parameter logic [7:0]  RES_MASK = RES_MASK_DEF,
    parameter logic [17:0] IMC_WORD = IMC_WORD_DEF
) (
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire hbi_style_e          style_in,
    input  wire logic                wide_in,
    input  wire logic                mux_in,
    input  wire logic                use_als_in,
    input  wire logic                fetch_en_in,
    input  wire logic                burst_en_in,
    input  wire logic                lat_out_en_in,
    input  wire logic                bus_ctrl_in_0,
    input  wire logic                bus_ctrl_in_1,
    input  wire logic                bus_ctrl_in_2,
    input  wire logic                aux_strobe_pin_in,
    input  wire logic                aux_high_write_pin_in,
    input  wire logic [LO_W-1:0]     addr_data_port_in,
    output logic      [LO_W-1:0]     addr_data_port_out,
    output logic      [1:0]          addr_data_port_oe_n_out,
    input  wire logic [LO_W-1:0]     data_fg_in,
    output logic      [LO_W-1:0]     data_fg_out,
    output logic      [1:0]          data_fg_oe_n_out,
    input  wire logic [IMC_BITS-1:0] port_abc_in,
    input  wire logic [NIB_CNT-1:0]  imc_pt_in,
    input  wire logic [NIB_CNT-1:0]  imc_src_ale_in,
    input  wire logic [5:0]          imc_mode_in,
    output logic      [IMC_BITS-1:0] imc_pld_out,
    output logic                     ctrl2_pld_out,
    output logic      [FULL_W-1:0]   latched_addr_out,
    output logic      [FULL_W-1:0]   int_addr_out,
    output logic      [LO_W-1:0]     int_wdata_out,
    output logic      [1:0]          int_we_out,
    output logic                     int_rd_out,
    input  wire logic [LO_W-1:0]     int_rdata_in
);

    // ========================================================================
    // strobe roles per host style
    // ========================================================================
    logic            c0, c1, c2, ale, a0;
    logic            sty_int, sty_wrh, sty_siz, sty_lds, swap;
    logic            c2_fetch, c2_used, ds_any, rd_act, wr_act;
    logic [1:0]      lanes_pin_rd, lanes_pin_wr, lanes_int_wr;

    assign c0       = bus_ctrl_in_0;
    assign c1       = bus_ctrl_in_1;
    assign c2       = bus_ctrl_in_2;
    assign ale      = aux_strobe_pin_in;
    assign sty_wrh  = (style_in == STY_WRL_WRH);
    assign sty_int  = (style_in == STY_WR_RD_BHE) | sty_wrh;
    assign sty_siz  = (style_in == STY_RW_DS_SIZ);
    assign sty_lds  = (style_in == STY_RW_LDS_UDS);
    // r/w style hosts put the even byte on the upper lane
    assign swap     = wide_in & ~sty_int;
    assign c2_fetch = fetch_en_in & (sty_wrh | ((style_in == STY_WR_RD_BHE) & ~wide_in));
    assign c2_used  = sty_siz | sty_lds | ((style_in == STY_WR_RD_BHE) & wide_in) | c2_fetch;
    assign ds_any   = sty_siz ? ~c1 : (~c1 | ~c2);
    assign rd_act   = sty_int ? (~c1 | (c2_fetch & ~c2)) : (c0 & ds_any);
    assign wr_act   = sty_int ? (~c0 | (sty_wrh & ~aux_high_write_pin_in))
                              : (~c0 & ds_any);

    // ========================================================================
    // address path: strobe latch, direct address, burst low bits
    // ========================================================================
    logic [LO_W-1:0]   addr_lat_r, addr_lat_nxt;
    logic [HI_W-1:0]   hi_lat_r, hi_lat_nxt;
    logic              lat_use;
    logic [3:0]        burst_lo;
    logic [FULL_W-1:0] eff_addr;
    logic              res_hit, imc_hit, any_hit;

    assign lat_use      = mux_in | use_als_in | burst_en_in;
    // reloads on every clk_in edge while the strobe is high, holds the last capture once it falls
    assign addr_lat_nxt = (ale & lat_use) ? addr_data_port_in : addr_lat_r;
    assign hi_lat_nxt   = (ale & lat_use) ? port_abc_in[HI_W-1:0] : hi_lat_r;
    // burst: port holds A19-A4, port F low nibble steps A3-A0; a 16-bit bus steps A3-A1 and holds A0 at zero
    assign burst_lo     = wide_in ? {data_fg_in[3:1], 1'b0} : data_fg_in[3:0];
    assign eff_addr     = burst_en_in ? {addr_lat_r, burst_lo}
                        : lat_use ? {hi_lat_r, addr_lat_r}
                        : {port_abc_in[HI_W-1:0], addr_data_port_in};
    assign a0           = eff_addr[0];
    assign imc_hit      = (eff_addr[FULL_W-1:2] == IMC_WORD);
    assign res_hit      = ((eff_addr[FULL_W-1:12] & RES_MASK) == RES_BASE) & ~imc_hit;
    assign any_hit      = imc_hit | res_hit;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_lat_r <= '0;
            hi_lat_r   <= '0;
        end else begin
            addr_lat_r <= addr_lat_nxt;
            hi_lat_r   <= hi_lat_nxt;
        end
    end

    // ========================================================================
    // data lanes: lane 0 is pins 7:0, lane 1 is pins 15:8
    // ========================================================================
    always_comb begin
        lanes_pin_rd = 2'h1;
        lanes_pin_wr = 2'h1;
        if (wide_in) begin
            case (style_in)
                STY_WR_RD_BHE: begin
                    lanes_pin_rd = {~c2, ~a0};
                    lanes_pin_wr = {~c2, ~a0};
                end
                STY_WRL_WRH: begin
                    lanes_pin_rd = 2'h3;
                    lanes_pin_wr = {~aux_high_write_pin_in, ~c0};
                end
                STY_RW_DS_SIZ: begin
                    lanes_pin_rd = a0 ? 2'h1 : {1'b1, ~c2};
                    lanes_pin_wr = lanes_pin_rd;
                end
                STY_RW_LDS_UDS: begin
                    lanes_pin_rd = {~c2, ~c1};
                    lanes_pin_wr = {~c2, ~c1};
                end
                default: begin
                    lanes_pin_rd = 2'h3;
                    lanes_pin_wr = 2'h3;
                end
            endcase
        end
    end

    assign lanes_int_wr = !wide_in ? {a0, ~a0}
                        : swap ? {lanes_pin_wr[0], lanes_pin_wr[1]} : lanes_pin_wr;

    // ========================================================================
    // read data: macrocell readback or internal resource
    // ========================================================================
    logic [31:0]     imc_bytes;
    logic [LO_W-1:0] rd_word, rd_pin, wr_pin, wr_word;
    logic [IMC_BITS-1:0] imc_r;
    logic            drive;

    assign imc_bytes = {8'h00, imc_r};
    assign rd_word   = imc_hit ? (eff_addr[1] ? imc_bytes[31:16] : imc_bytes[15:0])
                               : int_rdata_in;
    assign rd_pin    = !wide_in ? {8'h00, (a0 ? rd_word[15:8] : rd_word[7:0])}
                     : swap ? {rd_word[7:0], rd_word[15:8]} : rd_word;
    assign wr_pin    = mux_in ? addr_data_port_in : data_fg_in;
    assign wr_word   = !wide_in ? {wr_pin[7:0], wr_pin[7:0]}
                     : swap ? {wr_pin[7:0], wr_pin[15:8]} : wr_pin;
    assign drive     = rd_act & any_hit;

    // ========================================================================
    // pin drivers; an undecoded read leaves both ports released
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_data_port_out      <= '0;
            addr_data_port_oe_n_out <= LANES_OFF;
            data_fg_out             <= '0;
            data_fg_oe_n_out        <= LANES_OFF;
        end else begin
            addr_data_port_out      <= rd_pin;
            addr_data_port_oe_n_out <= (mux_in & drive) ? ~lanes_pin_rd : LANES_OFF;
            data_fg_out             <= rd_pin;
            data_fg_oe_n_out        <= (~mux_in & drive) ? ~lanes_pin_rd : LANES_OFF;
        end
    end

    // ========================================================================
    // internal bus: writes commit on the trailing edge of the strobe
    // ========================================================================
    logic       wr_hit, wr_q_r;
    logic [1:0] lanes_r;

    // macrocells are read-only, so only resource hits may write
    assign wr_hit = wr_act & res_hit;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q_r        <= 1'b0;
            lanes_r       <= '0;
            int_addr_out  <= '0;
            int_wdata_out <= '0;
            int_we_out    <= '0;
            int_rd_out    <= 1'b0;
        end else begin
            wr_q_r     <= wr_hit;
            int_rd_out <= rd_act & res_hit;
            int_we_out <= (wr_q_r & ~wr_hit) ? lanes_r : 2'h0;
            if ((rd_act | wr_act) & res_hit) begin
                int_addr_out <= eff_addr;
            end
            if (wr_hit) begin
                int_wdata_out <= wr_word;
                lanes_r       <= lanes_int_wr;
            end
        end
    end

    // ========================================================================
    // spare control input and latched address output
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl2_pld_out    <= 1'b0;
            latched_addr_out <= '0;
        end else begin
            ctrl2_pld_out    <= c2_used ? 1'b0 : c2;
            latched_addr_out <= lat_out_en_in ? {hi_lat_r, addr_lat_r} : '0;
        end
    end

    // ========================================================================
    // input macrocells, one nibble per enable source
    // ========================================================================
    logic [NIB_CNT-1:0] en_prev_r;

    generate
        for (genvar k = 0; k < NIB_CNT; k++) begin : g_imc
            logic       en;
            logic [1:0] mode;
            assign en   = imc_src_ale_in[k] ? ale : imc_pt_in[k];
            assign mode = imc_mode_in[2*(k/2) +: 2];
            // register mode needs the previous enable to find its rising edge
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    en_prev_r[k]   <= 1'b0;
                    imc_r[4*k +: 4] <= '0;
                end else begin
                    en_prev_r[k] <= en;
                    if ((mode == IMC_PASS) | ((mode == IMC_LATCH) & en) |
                        ((mode == IMC_REG) & en & ~en_prev_r[k])) begin
                        imc_r[4*k +: 4] <= port_abc_in[4*k +: 4];
                    end
                end
            end
        end
    endgenerate

    assign imc_pld_out = imc_r;

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wr_end;
        wr_hit ##1 !wr_hit;
    endsequence

    a_ad_read_only: assert property (
        (addr_data_port_oe_n_out != LANES_OFF) |-> $past(mux_in & rd_act & any_hit))
        else $error("address/data port driven outside an internal read");
    a_fg_quiet: assert property (
        (data_fg_oe_n_out != LANES_OFF) |-> $past(!mux_in & rd_act & any_hit))
        else $error("data port driven outside a non-multiplexed read");
    a_write_trailing: assert property (
        s_wr_end |=> (int_we_out != 2'h0))
        else $error("write not committed at strobe end");
    a_no_stray_we: assert property (
        (int_we_out != 2'h0) |-> $past(wr_q_r & ~wr_hit))
        else $error("write pulse without a decoded write");
    a_ale_capture: assert property (
        (ale & mux_in) |=> (addr_lat_r == $past(addr_data_port_in)))
        else $error("address not captured on strobe");
    a_direct_addr: assert property (
        (!lat_use && wr_hit) |=> (int_addr_out[LO_W-1:0] == $past(addr_data_port_in)))
        else $error("direct address not used");
    a_ctrl2_free: assert property (
        !c2_used |=> (ctrl2_pld_out == $past(c2)))
        else $error("spare control input not passed on");
    a_bhe_lanes: assert property (
        (wide_in && style_in == STY_WR_RD_BHE && !mux_in && drive && !a0 && c2)
        |=> (data_fg_oe_n_out == 2'h2))
        else $error("even byte lane not selected");
    a_burst_hold: assert property (
        (burst_en_in && !ale) |=> $stable(addr_lat_r))
        else $error("upper address moved during burst");
    a_imc_latch: assert property (
        (imc_src_ale_in[0] && ale && imc_mode_in[1:0] == IMC_LATCH)
        |=> (imc_pld_out[3:0] == $past(port_abc_in[3:0])))
        else $error("macrocell missed strobe capture");
    a_imc_readback: assert property (
        (mux_in && !wide_in && rd_act && imc_hit && eff_addr[1:0] == 2'h0)
        |=> (addr_data_port_out[7:0] == $past(imc_pld_out[7:0])))
        else $error("macrocell readback wrong");

endmodule : hbi_top

// File: verification/hbi_host_model.sv
// ============================================================================
// host model: drives the host side of the parallel bus from tasks
// ============================================================================
// assumes every task is entered just after a rising clk_in edge
`timescale 1ns/10ps
module hbi_host_model (
    input  wire logic        clk_in,
    output logic [3:0]       ctrl_out,   // {aux write high, ctrl2, ctrl1, ctrl0}
    output logic             als_out,
    output logic [15:0]      ad_out,
    output logic [3:0]       hi_addr_out
);
    // idle: strobes inactive, address strobe low
    initial begin
        ctrl_out    = 4'hF;
        als_out     = 1'b0;
        ad_out      = 16'h0000;
        hi_addr_out = 4'h0;
    end
    // multiplexed address phase; pins then show the inverse, never a stale address
    task automatic addr_phase(input logic [19:0] a);
        als_out     = 1'b1;
        ad_out      = a[15:0];
        hi_addr_out = a[19:16];
        @(posedge clk_in);
        #1;
        als_out = 1'b0;
        @(posedge clk_in);
        #1;
        ad_out = ~a[15:0];
    endtask : addr_phase
    // address straight on the pins, no strobe pulse
    task automatic set_addr(input logic [19:0] a);
        ad_out      = a[15:0];
        hi_addr_out = a[19:16];
    endtask : set_addr
    // write strobe held two edges; lanes follow a0 and the byte enables given
    task automatic strobe(input logic [3:0] pins, input logic [15:0] d);
        ad_out   = d;
        ctrl_out = pins;
        repeat (2) @(posedge clk_in);
        #1;
        ctrl_out = 4'hF;
        @(posedge clk_in);
        #1;
        ad_out = ~d;
    endtask : strobe
    // left to the caller so a read can be sampled mid-cycle
    task automatic set_ctrl(input logic [3:0] pins);
        ctrl_out = pins;
    endtask : set_ctrl
endmodule : hbi_host_model

// File: verification/test_hbi_top.sv
// ============================================================================
// self-checking bench for the host bus interface
// ============================================================================
// assumes hbi_pkg compiled first; host model drives the bus pins
`timescale 1ns/10ps
module test_hbi_top import hbi_pkg::*;;
    logic               clk_in, rst_n_in, wide_in, mux_in, use_als_in, lat_out_en_in;
    hbi_style_e         style_in;
    logic [5:0]         imc_mode_in, imc_src_ale_in, imc_pt_in;
    logic [19:0]        abc_hi;
    logic [15:0]        int_rdata_in, fg_idle, addr_data_port_in, data_fg_in;
    logic [15:0]        addr_data_port_out, data_fg_out, int_wdata_out, host_ad;
    logic [1:0]         addr_data_port_oe_n_out, data_fg_oe_n_out, int_we_out, we_seen;
    logic [3:0]         host_ctrl, host_hi, rd_pins, step_lo, fg_low;
    logic               host_als, ctrl2_pld_out, int_rd_out, fetch_en_in, burst_en_in, we_clr;
    logic [23:0]        imc_pld_out;
    logic [19:0]        latched_addr_out, int_addr_out;
    int                 we_cnt, n_mismatch, total_checks;
    // shared pins: whoever is not driving shows the inverse or a running pattern
    assign addr_data_port_in = {addr_data_port_oe_n_out[1] ? host_ad[15:8] : addr_data_port_out[15:8],
                                addr_data_port_oe_n_out[0] ? host_ad[7:0] : addr_data_port_out[7:0]};
    // during a burst the host steps the low address bits on port F
    assign fg_low     = burst_en_in ? step_lo : fg_idle[3:0];
    assign data_fg_in = {data_fg_oe_n_out[1] ? fg_idle[15:8] : data_fg_out[15:8],
                         data_fg_oe_n_out[0] ? {fg_idle[7:4], fg_low} : data_fg_out[7:0]};
    hbi_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .style_in(style_in), .wide_in(wide_in),
        .mux_in(mux_in), .use_als_in(use_als_in), .fetch_en_in(fetch_en_in),
        .burst_en_in(burst_en_in),
        .lat_out_en_in(lat_out_en_in), .bus_ctrl_in_0(host_ctrl[0]), .bus_ctrl_in_1(host_ctrl[1]),
        .bus_ctrl_in_2(host_ctrl[2]), .aux_strobe_pin_in(host_als),
        .aux_high_write_pin_in(host_ctrl[3]), .addr_data_port_in(addr_data_port_in),
        .addr_data_port_out(addr_data_port_out), .addr_data_port_oe_n_out(addr_data_port_oe_n_out),
        .data_fg_in(data_fg_in), .data_fg_out(data_fg_out), .data_fg_oe_n_out(data_fg_oe_n_out),
        .port_abc_in({abc_hi, host_hi}), .imc_pt_in(imc_pt_in), .imc_src_ale_in(imc_src_ale_in),
        .imc_mode_in(imc_mode_in), .imc_pld_out(imc_pld_out), .ctrl2_pld_out(ctrl2_pld_out),
        .latched_addr_out(latched_addr_out), .int_addr_out(int_addr_out),
        .int_wdata_out(int_wdata_out), .int_we_out(int_we_out), .int_rd_out(int_rd_out),
        .int_rdata_in(int_rdata_in));
    hbi_host_model host (.clk_in(clk_in), .ctrl_out(host_ctrl), .als_out(host_als),
        .ad_out(host_ad), .hi_addr_out(host_hi));
    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // collects write pulses so a doubled or missing pulse is seen; we_clr empties it
    always @(posedge clk_in) begin
        fg_idle <= rst_n_in ? fg_idle + 16'h0001 : 16'h0000;
        if (!rst_n_in || we_clr) begin
            we_seen <= 2'h0;
            we_cnt  <= 0;
        end else if (int_we_out !== 2'h0) begin
            we_seen <= we_seen | int_we_out;
            we_cnt  <= we_cnt + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // read with the strobes in rd_pins; oe is the expected oe_n, 3 for a miss
    task automatic rd_check(input logic [19:0] a, input logic [15:0] exp, input logic [1:0] oe);
        if (mux_in) host.addr_phase(a);
        else host.set_addr(a);
        host.set_ctrl(rd_pins);
        tick(2);
        check(int_rd_out, (oe != 2'h3) && (a[19:2] != IMC_WORD_DEF));
        if (mux_in) begin
            check(addr_data_port_oe_n_out, oe);
            if (oe != 2'h3) check(addr_data_port_out, exp);
        end else begin
            check(data_fg_oe_n_out, oe);
            if (oe != 2'h3) check(data_fg_out, exp);
            check(addr_data_port_oe_n_out, 2'h3);
        end
        host.set_ctrl(4'hF);
        tick(3);
        check({addr_data_port_oe_n_out, data_fg_oe_n_out}, 4'hF);
    endtask : rd_check
    // multiplexed write; pins always carry 1234, wd is the expected internal word
    task automatic wr_check(input hbi_style_e s, input logic [19:0] a, input logic [3:0] pins,
                            input logic [1:0] lanes, input logic [15:0] wd);
        style_in = s;
        we_clr   = 1'b1;
        host.addr_phase(a);
        we_clr   = 1'b0;
        host.strobe(pins, 16'h1234);
        tick(3);
        check(we_seen, lanes);
        check(we_cnt, (lanes == 2'h0) ? 0 : 1);
        check(int_wdata_out & {{8{lanes[1]}}, {8{lanes[0]}}}, wd);
    endtask : wr_check
    task automatic t_mux_read;
        rd_check(20'h31234, 16'hA55A, 2'h0);
        check(latched_addr_out, 20'h31234);
        check(int_addr_out, 20'h31234);
        rd_check(20'hF1234, 16'h0000, 2'h3);
        check(int_addr_out, 20'h31234);
        rd_check(20'h0FF00, 16'h3C50, 2'h0);
        rd_check(20'h0FF02, 16'h00A5, 2'h0);
    endtask : t_mux_read
    task automatic t_writes;
        wr_check(STY_WR_RD_BHE, 20'h00100, 4'hA, 2'h3, 16'h1234);
        wr_check(STY_WR_RD_BHE, 20'h00101, 4'hA, 2'h2, 16'h1200);
        wr_check(STY_WR_RD_BHE, 20'h00102, 4'hE, 2'h1, 16'h0034);
        wr_check(STY_WRL_WRH, 20'h00100, 4'h6, 2'h3, 16'h1234);
        wr_check(STY_RW_DS_SIZ, 20'h00100, 4'h8, 2'h3, 16'h3412);
        wr_check(STY_RW_DS_SIZ, 20'h00100, 4'hC, 2'h1, 16'h0012);
        wr_check(STY_RW_LDS_UDS, 20'h00100, 4'hC, 2'h2, 16'h3400);
        wr_check(STY_WR_RD_BHE, 20'hF0100, 4'hA, 2'h0, 16'h0000);
    endtask : t_writes
    // port A latched by the address strobe, B low nibble by a product term, C passes
    task automatic t_imc;
        imc_mode_in    = 6'h05;
        imc_src_ale_in = 6'h03;
        host.addr_phase(20'h90000);
        tick(1);
        abc_hi[3:0] = 4'hE;
        imc_pt_in[2] = 1'b1;
        tick(3);
        imc_pt_in[2] = 1'b0;
        tick(1);
        abc_hi[7:4] = 4'hF;
        tick(3);
        check(imc_pld_out, 24'hA53C59);
    endtask : t_imc
    task automatic t_nonmux;
        mux_in     = 1'b0;
        use_als_in = 1'b0;
        rd_check(20'h10456, 16'hA55A, 2'h0);
        check(int_addr_out, 20'h10456);
        rd_check(20'hF0456, 16'h0000, 2'h3);
        rd_pins = 4'hD;
        rd_check(20'h10458, 16'hA55A, 2'h2);
        host.set_addr(20'h20458);
        tick(1);
        host.strobe(4'hA, 16'h0458);
        check(int_addr_out, 20'h20458);
    endtask : t_nonmux
    // burst fetch: upper address latched once, low bits stepped on port F
    task automatic t_burst;
        burst_en_in = 1'b1;
        step_lo     = 4'h6;
        rd_check(20'h00010, 16'hA55A, 2'h0);
        check(int_addr_out, 20'h00106);
        step_lo = 4'hA;
        host.set_ctrl(rd_pins);
        tick(2);
        check(int_addr_out, 20'h0010A);
        check(latched_addr_out, 20'h00010);
        host.set_ctrl(4'hF);
        tick(2);
        burst_en_in = 1'b0;
    endtask : t_burst
    // 8-bit host: fetch strobe reads, byte picked by address bit zero, latch output off
    task automatic t_narrow;
        {mux_in, wide_in, lat_out_en_in, fetch_en_in} = 4'h9;
        rd_pins      = 4'hB;
        int_rdata_in = 16'h5AC3;
        rd_check(20'h00201, 16'h005A, 2'h2);
        check(latched_addr_out, 20'h00000);
        rd_pins = 4'h9;
        rd_check(20'h0FF00, 16'h00E0, 2'h2);
    endtask : t_narrow
    // ctrl2 reaches the logic only where the host type leaves it unused
    task automatic t_ctrl2;
        style_in = STY_WRL_WRH;
        host.set_ctrl(4'hB);
        tick(3);
        check(ctrl2_pld_out, 1'b0);
        host.set_ctrl(4'hF);
        tick(3);
        check(ctrl2_pld_out, 1'b1);
        style_in = STY_WR_RD_BHE;
        tick(3);
        check(ctrl2_pld_out, 1'b0);
    endtask : t_ctrl2
    // hang guard, far beyond the under two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        close_out();
    end
    initial begin
        {rst_n_in, n_mismatch, total_checks, we_clr, fetch_en_in, burst_en_in} = '0;
        {wide_in, mux_in, use_als_in, lat_out_en_in} = 4'hF;
        rd_pins = 4'h9;
        style_in = STY_WR_RD_BHE;
        {imc_mode_in, imc_src_ale_in, imc_pt_in} = '0;
        abc_hi = {8'hA5, 8'h3C, 4'h5};
        int_rdata_in = 16'hA55A;
        repeat (12) @(posedge clk_in);
        check({addr_data_port_oe_n_out, data_fg_oe_n_out}, 4'hF);
        #1;
        rst_n_in = 1'b1;
        tick(1);
        t_mux_read();
        t_writes();
        t_imc();
        t_burst();
        t_ctrl2();
        t_nonmux();
        t_narrow();
        close_out();
    end
endmodule : test_hbi_top
